// ---- hw/nrc_pkg.sv ----
package nrc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_UNLOCK = 4'h1;
  localparam logic [3:0] REG_PTR_LO = 4'h2;
  localparam logic [3:0] REG_PTR_HI = 4'h3;
  localparam logic [3:0] REG_PTR_UP = 4'h4;
  localparam logic [3:0] REG_LATCH = 4'h5;
  localparam logic [3:0] REG_IRQ_STAT = 4'h6;
  localparam logic [3:0] REG_IRQ_MASK = 4'h7;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CTL_SPACE = 7;
  localparam int CTL_CFG = 6;
  localparam int CTL_ROW_ERASE = 4;
  localparam int CTL_WERR = 3;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_WSTART = 1;
  localparam int CTL_RSTART = 0;

  // ****************************************************************
  // unlock keys, pointer layout, interrupt bits
  // ****************************************************************
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam int PTR_W = 22;
  localparam int ROW_LSB = 6;
  localparam logic [5:0] ROW_OFFSET_ZERO = 6'h00;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RDONE = 1;
  localparam int IRQ_REFUSED = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLK_FREQ_HZ = 250_000_000;
  localparam longint ERASE_TIME_MS = 2;
  localparam longint WRITE_TIME_MS = 2;
  localparam int ERASE_CYCLES = int'(ERASE_TIME_MS * CLK_FREQ_HZ / 1000);
  localparam int WRITE_CYCLES = int'(WRITE_TIME_MS * CLK_FREQ_HZ / 1000);
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    UL_IDLE = 2'b00,
    UL_GOT1 = 2'b01,
    UL_ARMED = 2'b10
  } nrc_unlock_e;

  typedef enum logic [0:0] {
    CY_IDLE = 1'b0,
    CY_BUSY = 1'b1
  } nrc_cycle_e;

  typedef struct packed {
    logic rd;
    logic write;
    logic erase;
    logic flash;
    logic cfg;
    logic [PTR_W-1:0] addr;
    logic [7:0] wdata;
  } nrc_mem_req_s;

endpackage : nrc_pkg

// ---- hw/nrc_flash_ctrl.sv ----
`timescale 1ns/1ps
module nrc_flash_ctrl
  import nrc_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYCLES,
  parameter int WRITE_CYC = WRITE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_por,
  input wire logic i_ce,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output nrc_mem_req_s o_mem,
  input wire logic [7:0] i_mem_rdata,
  output logic o_cpu_stall,
  output logic o_irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic space_q;
  logic space_d;
  logic cfg_q;
  logic cfg_d;
  logic erase_q;
  logic erase_d;
  logic werr_q;
  logic werr_d;
  logic permit_q;
  logic permit_d;
  logic rstart_q;
  logic rstart_d;
  logic [PTR_W-1:0] ptr_q;
  logic [PTR_W-1:0] ptr_d;
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] stat_d;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] mask_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  nrc_unlock_e ul_q;
  nrc_unlock_e ul_d;
  nrc_cycle_e cy_q;
  nrc_cycle_e cy_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic op_erase_q;
  logic op_erase_d;
  logic op_flash_q;
  logic op_flash_d;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
                                   input logic [3:0] idx);
    return strobe && (addr == idx);
  endfunction : reg_hit

  function automatic logic field_next(input logic wr, input logic [7:0] data, input int pos,
                                      input logic old);
    return wr ? data[pos] : old;
  endfunction : field_next

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire wr_ctrl = reg_hit(i_wr, i_addr, REG_CTRL);
  wire wr_unlock = reg_hit(i_wr, i_addr, REG_UNLOCK);
  wire wr_plo = reg_hit(i_wr, i_addr, REG_PTR_LO);
  wire wr_phi = reg_hit(i_wr, i_addr, REG_PTR_HI);
  wire wr_pup = reg_hit(i_wr, i_addr, REG_PTR_UP);
  wire wr_latch = reg_hit(i_wr, i_addr, REG_LATCH);
  wire wr_stat = reg_hit(i_wr, i_addr, REG_IRQ_STAT);
  wire wr_mask = reg_hit(i_wr, i_addr, REG_IRQ_MASK);

  // ****************************************************************
  // control field updates
  // ****************************************************************
  wire busy = (cy_q == CY_BUSY);
  wire new_space = field_next(wr_ctrl, i_wdata, CTL_SPACE, space_q);
  wire new_cfg = field_next(wr_ctrl, i_wdata, CTL_CFG, cfg_q);
  wire new_erase = field_next(wr_ctrl, i_wdata, CTL_ROW_ERASE, erase_q);
  wire new_permit = field_next(wr_ctrl, i_wdata, CTL_PERMIT, permit_q);
  wire ask_start = wr_ctrl && i_wdata[CTL_WSTART];
  // start only straight after both keys, with writes permitted
  wire go_start = ask_start && (ul_q == UL_ARMED) && new_permit && !busy;
  wire refused = ask_start && !go_start;
  // read refused while program flash is selected
  wire go_read = wr_ctrl && i_wdata[CTL_RSTART] && !new_space && !busy;
  wire cnt_end = busy && (cnt_q == CNT_ONE);
  wire [CNT_W-1:0] erase_len = CNT_W'(ERASE_CYC);
  wire [CNT_W-1:0] write_len = CNT_W'(WRITE_CYC);

  assign space_d = new_space;
  assign cfg_d = new_cfg;
  // hardware clears the row-erase arm when the erase completes
  assign erase_d = (cnt_end && op_erase_q) ? 1'b0 : new_erase;
  assign werr_d = field_next(wr_ctrl, i_wdata, CTL_WERR, werr_q);
  assign permit_d = new_permit;
  // read lasts exactly one cycle, software cannot clear it
  assign rstart_d = go_read;

  // ****************************************************************
  // unlock sequence
  // ****************************************************************
  always_comb begin
    ul_d = ul_q;
    if (wr_unlock && i_wdata == UNLOCK_KEY1) begin
      ul_d = UL_GOT1;
    end else if (wr_unlock && i_wdata == UNLOCK_KEY2 && ul_q == UL_GOT1) begin
      ul_d = UL_ARMED;
    end else if (i_wr) begin
      ul_d = UL_IDLE;
    end
  end

  // ****************************************************************
  // self-timed cycle
  // ****************************************************************
  always_comb begin
    cy_d = cy_q;
    cnt_d = cnt_q;
    op_erase_d = op_erase_q;
    op_flash_d = op_flash_q;
    unique case (cy_q)
      CY_IDLE: begin
        if (go_start) begin
          cy_d = CY_BUSY;
          op_erase_d = new_erase && new_space && !new_cfg;
          op_flash_d = new_space || new_cfg;
          // internal timer, never software, sets the length
          cnt_d = (new_erase && new_space) ? erase_len : write_len;
        end
      end
      CY_BUSY: begin
        if (cnt_end) begin
          cy_d = CY_IDLE;
          // drop the operation kind so later reads take the flash select from the space bit alone
          op_erase_d = 1'b0;
          op_flash_d = 1'b0;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
    endcase
  end

  // ****************************************************************
  // pointer and latch
  // ****************************************************************
  wire [5:0] ptr_up_d = wr_pup ? i_wdata[5:0] : ptr_q[21:16];
  wire [7:0] ptr_hi_d = wr_phi ? i_wdata : ptr_q[15:8];
  wire [7:0] ptr_lo_d = wr_plo ? i_wdata : ptr_q[7:0];
  assign ptr_d = {ptr_up_d, ptr_hi_d, ptr_lo_d};
  assign latch_d = rstart_q ? i_mem_rdata : (wr_latch ? i_wdata : latch_q);

  // ****************************************************************
  // interrupts: set wins over write-one-clear
  // ****************************************************************
  wire [IRQ_W-1:0] irq_set;
  assign irq_set[IRQ_DONE] = cnt_end;
  assign irq_set[IRQ_RDONE] = rstart_q;
  assign irq_set[IRQ_REFUSED] = refused;
  wire [IRQ_W-1:0] irq_clr = wr_stat ? i_wdata[IRQ_W-1:0] : IRQ_RESET;
  assign stat_d = irq_set | (stat_q & ~irq_clr);
  assign mask_d = wr_mask ? i_wdata[IRQ_W-1:0] : mask_q;

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire [7:0] ctrl_view;
  assign ctrl_view[CTL_SPACE] = space_q;
  assign ctrl_view[CTL_CFG] = cfg_q;
  assign ctrl_view[CTL_CFG - 1] = 1'b0;
  assign ctrl_view[CTL_ROW_ERASE] = erase_q;
  assign ctrl_view[CTL_WERR] = werr_q;
  assign ctrl_view[CTL_PERMIT] = permit_q;
  assign ctrl_view[CTL_WSTART] = busy;
  assign ctrl_view[CTL_RSTART] = rstart_q;
  logic [7:0] rsel;
  always_comb begin
    unique case (i_addr)
      REG_CTRL: rsel = ctrl_view;
      REG_PTR_LO: rsel = ptr_q[7:0];
      REG_PTR_HI: rsel = ptr_q[15:8];
      REG_PTR_UP: rsel = {2'b00, ptr_q[21:16]};
      REG_LATCH: rsel = latch_q;
      REG_IRQ_STAT: rsel = {5'h00, stat_q};
      REG_IRQ_MASK: rsel = {5'h00, mask_q};
      default: rsel = BYTE_ZERO;
    endcase
  end
  assign rdata_d = i_rd ? rsel : BYTE_ZERO;

  // ****************************************************************
  // flops
  // ****************************************************************
  // space and config selects survive system reset (power-on reset clears them) so a failed access can be traced
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      space_q <= 1'b0;
    end else if (i_sys_rst) begin
      space_q <= space_q;
    end else if (i_ce) begin
      space_q <= space_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_por) begin
      cfg_q <= 1'b0;
    end else if (i_sys_rst) begin
      cfg_q <= cfg_q;
    end else if (i_ce) begin
      cfg_q <= cfg_d;
    end
  end

  // error flag records a cycle cut short by system reset
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      werr_q <= 1'b0;
    end else if (i_sys_rst) begin
      werr_q <= werr_q | busy;
    end else if (i_ce) begin
      werr_q <= werr_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      erase_q <= 1'b0;
    end else if (i_ce) begin
      erase_q <= erase_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      permit_q <= 1'b0;
    end else if (i_ce) begin
      permit_q <= permit_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      rstart_q <= 1'b0;
    end else if (i_ce) begin
      rstart_q <= rstart_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      ul_q <= UL_IDLE;
    end else if (i_ce) begin
      ul_q <= ul_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      cy_q <= CY_IDLE;
    end else if (i_ce) begin
      cy_q <= cy_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      cnt_q <= '0;
    end else if (i_ce) begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      op_erase_q <= 1'b0;
    end else if (i_ce) begin
      op_erase_q <= op_erase_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      op_flash_q <= 1'b0;
    end else if (i_ce) begin
      op_flash_q <= op_flash_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      ptr_q <= '0;
    end else if (i_ce) begin
      ptr_q <= ptr_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      latch_q <= BYTE_ZERO;
    end else if (i_ce) begin
      latch_q <= latch_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      stat_q <= IRQ_RESET;
    end else if (i_ce) begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      mask_q <= IRQ_RESET;
    end else if (i_ce) begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_por) begin
      rdata_q <= BYTE_ZERO;
    end else if (i_ce) begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // memory request and outputs
  // ****************************************************************
  assign o_mem.rd = rstart_q;
  wire erasing = busy && op_erase_q;
  wire writing = busy && !op_erase_q;
  assign o_mem.write = writing;
  assign o_mem.erase = erasing;
  assign o_mem.flash = op_flash_q || (rstart_q && space_q);
  assign o_mem.cfg = cfg_q;
  // whole 64-byte row, low pointer bits dropped
  assign o_mem.addr = erasing ? {ptr_q[PTR_W-1:ROW_LSB], ROW_OFFSET_ZERO} : ptr_q;
  // data latch not presented during an erase
  assign o_mem.wdata = erasing ? BYTE_ZERO : latch_q;
  assign o_cpu_stall = busy && op_flash_q;
  assign o_irq = |(stat_q & mask_q);
  assign o_rdata = rdata_q;

endmodule : nrc_flash_ctrl

// ---- verification/nrc_flash_ctrl_asserts.sv ----
`timescale 1ns/1ps
module nrc_flash_ctrl_asserts
  import nrc_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYCLES,
  parameter int WRITE_CYC = WRITE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_por,
  input wire logic i_ce,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire nrc_mem_req_s o_mem,
  input wire logic [7:0] i_mem_rdata,
  input wire logic o_cpu_stall,
  input wire logic o_irq
);
  wire logic ctl_w = i_wr && i_ce && i_addr == REG_CTRL;
  wire logic key1_w = i_wr && i_ce && i_addr == REG_UNLOCK && i_wdata == UNLOCK_KEY1;
  wire logic key2_w = i_wr && i_ce && i_addr == REG_UNLOCK && i_wdata == UNLOCK_KEY2;
  wire logic start_w = ctl_w && i_wdata[CTL_WSTART];
  wire logic busy_w = o_mem.write || o_mem.erase;
  int cnt_q;
  always_ff @(posedge i_clk) begin
    cnt_q <= o_mem.erase ? (i_ce ? cnt_q + 1 : cnt_q) : 0;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst || i_por);
  sequence unlock_s;
    key1_w ##1 key2_w ##1 (start_w && i_wdata[CTL_PERMIT] && !busy_w);
  endsequence
  key_start_a: assert property (unlock_s |=> busy_w)
    else $error("unlocked start began no cycle");
  key_missing_a: assert property (start_w && !($past(key2_w) && $past(key1_w, 2))
    |=> !$rose(busy_w))
    else $error("cycle began without unlock");
  permit_gate_a: assert property (ctl_w && !i_wdata[CTL_PERMIT] |=> !$rose(busy_w))
    else $error("cycle began without permit");
  read_refuse_a: assert property (ctl_w && i_wdata[CTL_SPACE] |=> !o_mem.rd)
    else $error("read started with space bit set");
  read_pulse_a: assert property (o_mem.rd && i_ce |=> !o_mem.rd)
    else $error("read strobe longer than one cycle");
  erase_row_a: assert property (o_mem.erase |-> o_mem.addr[ROW_LSB-1:0] == ROW_OFFSET_ZERO)
    else $error("erase address not row aligned");
  erase_data_a: assert property (o_mem.erase |-> o_mem.wdata == BYTE_ZERO)
    else $error("erase carries data");
  erase_stall_a: assert property (o_mem.erase |-> o_cpu_stall)
    else $error("erase without stall");
  erase_len_a: assert property ($fell(o_mem.erase) && !$past(i_sys_rst || i_por)
    |-> cnt_q == ERASE_CYC && !o_cpu_stall)
    else $error("erase length wrong");
endmodule : nrc_flash_ctrl_asserts

bind nrc_flash_ctrl nrc_flash_ctrl_asserts #(.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC)) chk_u (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_por(i_por), .i_ce(i_ce), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem(o_mem),
  .i_mem_rdata(i_mem_rdata), .o_cpu_stall(o_cpu_stall), .o_irq(o_irq));

// ---- verification/test_nrc_flash_ctrl.sv ----
`timescale 1ns/1ps
module test_nrc_flash_ctrl import nrc_pkg::*; ;
  logic i_clk, i_sys_rst, i_por, i_ce, i_wr, i_rd, o_cpu_stall, o_irq;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, i_mem_rdata, o_rdata;
  nrc_mem_req_s o_mem;
  int fails, n_compared, cyc, n;
  nrc_flash_ctrl #(.ERASE_CYC(4), .WRITE_CYC(8)) dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_por(i_por), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem(o_mem),
    .i_mem_rdata(i_mem_rdata), .o_cpu_stall(o_cpu_stall), .o_irq(o_irq));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    i_addr <= a;
    i_wdata <= d;
  endtask : wr
  task automatic idle();
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(negedge i_clk);
  endtask : idle
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk("register read", o_rdata & m, e);
  endtask : rd
  task automatic ustart(input logic [7:0] d);
    wr(REG_UNLOCK, UNLOCK_KEY1);
    wr(REG_UNLOCK, UNLOCK_KEY2);
    wr(REG_CTRL, d);
    idle();
  endtask : ustart
  task automatic t_basic();
    rd(REG_CTRL, 8'h00, 8'hff);
    rd(4'h8, 8'h00, 8'hff);
    wr(REG_CTRL, 8'h01);
    idle();
    chk("read strobe", o_mem.rd, 1);
    chk("flash select", o_mem.flash, 0);
    rd(REG_LATCH, 8'h3c, 8'hff);
    rd(REG_CTRL, 8'h00, 8'h01);
    wr(REG_CTRL, 8'h81);
    idle();
    chk("read strobe", o_mem.rd, 0);
    wr(REG_IRQ_MASK, 8'h02);
    idle();
    chk("irq", o_irq, 1);
    wr(REG_IRQ_STAT, 8'h02);
    idle();
    chk("irq", o_irq, 0);
    $display("basic test done");
  endtask : t_basic
  task automatic t_erase();
    wr(REG_PTR_UP, 8'h2a);
    wr(REG_PTR_HI, 8'h5b);
    wr(REG_PTR_LO, 8'h7f);
    wr(REG_LATCH, 8'h99);
    ustart(8'h97);
    chk("erase", o_mem.erase, 1);
    chk("stall", o_cpu_stall, 1);
    chk("flash select", o_mem.flash, 1);
    chk("erase addr", o_mem.addr, {6'h2a, 8'h5b, 8'h40});
    chk("erase data", o_mem.wdata, 0);
    n = 0;
    while (o_mem.erase === 1'b1 && n < 50) begin
      n++;
      @(negedge i_clk);
    end
    chk("erase cycles", n, 4);
    chk("idle addr", o_mem.addr, {6'h2a, 8'h5b, 8'h7f});
    chk("stall", o_cpu_stall, 0);
    rd(REG_CTRL, 8'h80, 8'hfb);
    rd(REG_IRQ_STAT, 8'h01, 8'hff);
    wr(REG_IRQ_STAT, 8'h01);
    idle();
    $display("erase test done");
  endtask : t_erase
  task automatic t_lock();
    wr(REG_CTRL, 8'h86);
    idle();
    chk("write", o_mem.write, 0);
    wr(REG_UNLOCK, UNLOCK_KEY1);
    wr(REG_PTR_LO, 8'h00);
    wr(REG_UNLOCK, UNLOCK_KEY2);
    wr(REG_CTRL, 8'h86);
    idle();
    chk("write", o_mem.write, 0);
    ustart(8'h82);
    chk("write", o_mem.write, 0);
    rd(REG_IRQ_STAT, 8'h04, 8'hff);
    wr(REG_IRQ_MASK, 8'h04);
    idle();
    chk("irq", o_irq, 1);
    wr(REG_IRQ_STAT, 8'h04);
    wr(REG_IRQ_MASK, 8'h00);
    idle();
    $display("lock test done");
  endtask : t_lock
  task automatic t_werr();
    ustart(8'h06);
    chk("write", o_mem.write, 1);
    chk("stall", o_cpu_stall, 0);
    chk("write addr", o_mem.addr, {6'h2a, 8'h5b, 8'h00});
    chk("write data", o_mem.wdata, 8'h99);
    // 8 ticks plus 3 frozen edges; 4 busy cycles gone before counting
    @(posedge i_clk);
    i_ce <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_ce <= 1'b1;
    @(negedge i_clk);
    n = 0;
    while (o_mem.write === 1'b1 && n < 50) begin
      n++;
      @(negedge i_clk);
    end
    chk("write cycles", n, 7);
    ustart(8'hc6);
    chk("stall", o_cpu_stall, 1);
    chk("config select", o_mem.cfg, 1);
    wr(REG_CTRL, 8'hc4);
    idle();
    chk("write", o_mem.write, 1);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(REG_CTRL, 8'hc8, 8'hc8);
    @(posedge i_clk);
    i_por <= 1'b1;
    @(posedge i_clk);
    i_por <= 1'b0;
    rd(REG_CTRL, 8'h00, 8'hc8);
    $display("error test done");
  endtask : t_werr
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    {i_sys_rst, i_por, i_ce} = 3'h7;
    {i_wr, i_rd, i_addr, i_wdata} = 14'h0;
    i_mem_rdata = 8'h3c;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    i_por <= 1'b0;
    t_basic();
    t_erase();
    t_lock();
    t_werr();
    conclude();
  end
endmodule : test_nrc_flash_ctrl
